// ---- inc/port_pm_runtime_defines.vh ----
`ifndef PORT_PM_RUNTIME_DEFINES_VH
`define PORT_PM_RUNTIME_DEFINES_VH

`define OFS_PORT_PM 32'h0000_0404
`define OFS_PORT_LINK 32'h0000_0408
`define OFS_PORT_STRIDE 32'h0000_0010
`define OFS_FRAME_INDEX 32'h0000_0000
`define OFS_INTR_BASE 32'h0000_0020
`define OFS_INTR_LAST 32'h0000_0100
`define INTR_STRIDE_SHIFT 5
`define NUM_INTR 8

`define SS_WR_MASK 32'h0001_FFFF
`define SS_STICKY_MASK 32'h0000_FFFF
`define HS_WR_MASK 32'hF000_FFF8
`define HS_STATUS_MASK 32'h0000_0007
`define INTR_ENABLE_BIT 1
`define INTR_PENDING_BIT 0
`define FRAME_WIDTH 14
`define LINK_ERR_WIDTH 16
`define RESET_VALUE 32'h0000_0000

`define CLK_PERIOD_NS 5
`define FRAME_TIME_NS 125000
`define FRAME_TICKS (`FRAME_TIME_NS / `CLK_PERIOD_NS)

`endif

// ---- rtl/frame_index_counter.v ----
`timescale 1ns/1ps
`include "port_pm_runtime_defines.vh"
module frame_index_counter #(
  parameter TICKS = `FRAME_TICKS
) (
  input wire clk,
  input wire rst_n,
  output reg [`FRAME_WIDTH-1:0] frame_ff
);
  reg [31:0] div_ff;
  wire tick;

  assign tick = (div_ff == TICKS - 1);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= 32'h0000_0000;
      frame_ff <= {`FRAME_WIDTH{1'b0}};
    end else begin
      div_ff <= tick ? 32'h0000_0000 : div_ff + 32'h0000_0001;
      if (tick) begin
        frame_ff <= frame_ff + {{(`FRAME_WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

// ---- rtl/port_pm_runtime_registers.v ----
`timescale 1ns/1ps
`include "port_pm_runtime_defines.vh"
module port_pm_runtime_registers #(
  parameter NUM_PORTS = 4,
  parameter SS_PORT_MASK = 4'b0011,
  parameter FRAME_TICKS = `FRAME_TICKS
) (
  input wire clk,
  input wire rst_n,
  input wire global_reset_input,
  input wire host_reset,
  input wire [31:0] bar0_base,
  input wire [31:0] op_offset,
  input wire [31:0] rt_offset,
  input wire reg_wr_en,
  input wire reg_rd_en,
  input wire [31:0] reg_addr,
  input wire [31:0] reg_wdata,
  output reg [31:0] reg_rdata,
  output reg reg_rd_valid,
  input wire [NUM_PORTS*3-1:0] sleep_entry_result,
  input wire [NUM_PORTS*16-1:0] link_error_count,
  input wire [`NUM_INTR-1:0] intr_event,
  output wire [NUM_PORTS*32-1:0] port_pm_ctrl,
  output wire [`NUM_INTR-1:0] intr_enable,
  output wire [`NUM_INTR-1:0] intr_pending,
  output wire [`FRAME_WIDTH-1:0] periodic_frame_counter
);

  ////////////////////////////////////////////////////////////////
  // address decode
  function [32:0] port_hit;
    input [31:0] rel;
    input [31:0] base;
    reg [31:0] d;
    begin
      d = rel - base;
      port_hit = {(d[3:0] == 4'h0) && ((d >> 4) < NUM_PORTS), d >> 4};
    end
  endfunction

  function is_superspeed;
    input [31:0] port;
    begin
      is_superspeed = (port < NUM_PORTS) && SS_PORT_MASK[port];
    end
  endfunction

  wire [31:0] op_rel = reg_addr - (bar0_base + op_offset);
  wire [31:0] rt_rel = reg_addr - (bar0_base + rt_offset);
  wire [32:0] pm_dec = port_hit(op_rel, `OFS_PORT_PM);
  wire [32:0] li_dec = port_hit(op_rel, `OFS_PORT_LINK);
  wire pm_hit = pm_dec[32];
  wire li_hit = li_dec[32];
  wire [31:0] pm_idx = pm_dec[31:0];
  wire [31:0] li_idx = li_dec[31:0];
  wire fi_hit = (rt_rel == `OFS_FRAME_INDEX);
  wire in_hit = (rt_rel[4:0] == 5'h00) && (rt_rel >= `OFS_INTR_BASE) && (rt_rel <= `OFS_INTR_LAST);
  wire [31:0] in_sh = (rt_rel >> `INTR_STRIDE_SHIFT) - 32'h0000_0001;
  wire [2:0] in_idx = in_sh[2:0];
  wire pm_ss = is_superspeed(pm_idx);
  wire li_ss = is_superspeed(li_idx);

  // one-hot write strobes
  reg [NUM_PORTS-1:0] pm_wr;
  reg [`NUM_INTR-1:0] in_wr;

  always @* begin
    pm_wr = {NUM_PORTS{1'b0}};
    in_wr = {`NUM_INTR{1'b0}};
    if (reg_wr_en && pm_hit) begin
      pm_wr[pm_idx] = 1'b1;
    end
    if (reg_wr_en && in_hit) begin
      in_wr[in_idx] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // global reset pin synchroniser
  // pin is asynchronous to clk
  reg global_reset_input_meta_ff;
  reg global_reset_input_ff;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      global_reset_input_meta_ff <= 1'b0;
      global_reset_input_ff <= 1'b0;
    end else begin
      global_reset_input_meta_ff <= global_reset_input;
      global_reset_input_ff <= global_reset_input_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////
  // port power-management registers
  reg [31:0] pm_ff [0:NUM_PORTS-1];
  integer p;

  function [31:0] wr_mask;
    input integer port;
    begin
      wr_mask = is_superspeed(port) ? `SS_WR_MASK : `HS_WR_MASK;
    end
  endfunction

  function [31:0] sticky_mask;
    input integer port;
    begin
      sticky_mask = is_superspeed(port) ? `SS_STICKY_MASK : 32'h0000_0000;
    end
  endfunction

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (p = 0; p < NUM_PORTS; p = p + 1) begin
        pm_ff[p] <= `RESET_VALUE;
      end
    end else begin
      for (p = 0; p < NUM_PORTS; p = p + 1) begin
        if (global_reset_input_ff) begin
          pm_ff[p] <= `RESET_VALUE;
        end else if (host_reset) begin
          // host reset keeps sticky timeouts
          pm_ff[p] <= pm_ff[p] & sticky_mask(p);
        end else if (pm_wr[p]) begin
          pm_ff[p] <= reg_wdata & wr_mask(p);
        end
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g = g + 1) begin : g_out
      assign port_pm_ctrl[g*32 +: 32] = pm_ff[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // interrupter management registers
  reg [`NUM_INTR-1:0] ie_ff;
  reg [`NUM_INTR-1:0] ip_ff;
  reg [`NUM_INTR-1:0] nxt_ie;
  reg [`NUM_INTR-1:0] nxt_ip;
  integer i;

  always @* begin
    nxt_ie = ie_ff;
    nxt_ip = ip_ff;
    for (i = 0; i < `NUM_INTR; i = i + 1) begin
      if (in_wr[i]) begin
        nxt_ie[i] = reg_wdata[`INTR_ENABLE_BIT];
        if (reg_wdata[`INTR_PENDING_BIT]) begin
          nxt_ip[i] = 1'b0;
        end
      end
      if (intr_event[i]) begin
        nxt_ip[i] = 1'b1; // set wins over clear
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ie_ff <= {`NUM_INTR{1'b0}};
      ip_ff <= {`NUM_INTR{1'b0}};
    end else if (host_reset) begin
      ie_ff <= {`NUM_INTR{1'b0}};
      ip_ff <= {`NUM_INTR{1'b0}};
    end else begin
      ie_ff <= nxt_ie;
      ip_ff <= nxt_ip;
    end
  end

  assign intr_enable = ie_ff;
  assign intr_pending = ip_ff;

  ////////////////////////////////////////////////////////////////
  // periodic frame counter
  frame_index_counter #(
    .TICKS(FRAME_TICKS)
  ) u_frame (
    .clk(clk),
    .rst_n(rst_n),
    .frame_ff(periodic_frame_counter)
  );

  ////////////////////////////////////////////////////////////////
  // read path
  reg [31:0] nxt_rdata;

  always @* begin
    // unmapped space reads zero
    nxt_rdata = 32'h0000_0000;
    if (pm_hit) begin
      nxt_rdata = pm_ff[pm_idx];
      if (!pm_ss) begin
        nxt_rdata = (pm_ff[pm_idx] & ~`HS_STATUS_MASK) | {29'h0, sleep_entry_result[pm_idx*3 +: 3]};
      end
    end else if (li_hit) begin
      if (li_ss) begin
        nxt_rdata = {16'h0000, link_error_count[li_idx*16 +: 16]};
      end
    end else if (fi_hit) begin
      nxt_rdata = {18'h0, periodic_frame_counter};
    end else if (in_hit) begin
      nxt_rdata = {30'h0, ie_ff[in_idx], ip_ff[in_idx]};
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rdata <= nxt_rdata;
      end
    end
  end

endmodule

// ---- testbench/pm_rt_checker.sv ----
`timescale 1ns/1ps
module pm_rt_checker (
  input wire clk,
  input wire rst_n,
  input wire global_reset_input,
  input wire host_reset,
  input wire reg_wr_en,
  input wire reg_rd_en,
  input wire reg_rd_valid,
  input wire [7:0] intr_event,
  input wire [127:0] port_pm_ctrl,
  input wire [7:0] intr_enable,
  input wire [7:0] intr_pending,
  input wire [13:0] periodic_frame_counter
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_global_reset_input;
    global_reset_input[*3];
  endsequence
  sequence s_hrst;
    (!global_reset_input)[*3] ##0 (host_reset && !reg_wr_en);
  endsequence
  property p_rdv;
    reg_rd_en |=> reg_rd_valid;
  endproperty
  a_rdv: assert property (p_rdv) else $error("read answer missing");
  property p_idle;
    !reg_rd_en |=> !reg_rd_valid;
  endproperty
  a_idle: assert property (p_idle) else $error("read answer without read");
  property p_step;
    $changed(periodic_frame_counter) |-> periodic_frame_counter == $past(periodic_frame_counter) + 14'h1;
  endproperty
  a_step: assert property (p_step) else $error("frame counter jumped");
  property p_ss;
    port_pm_ctrl[31:17] == 15'h0 && port_pm_ctrl[63:49] == 15'h0;
  endproperty
  a_ss: assert property (p_ss) else $error("superspeed upper bits set");
  property p_hs;
    port_pm_ctrl[91:80] == 12'h0 && port_pm_ctrl[123:112] == 12'h0;
  endproperty
  a_hs: assert property (p_hs) else $error("high-speed reserved bits set");
  property p_hrst;
    host_reset && intr_event == 8'h0 |=> intr_enable == 8'h0 && intr_pending == 8'h0;
  endproperty
  a_hrst: assert property (p_hrst) else $error("interrupter not cleared");
  property p_stky;
    s_hrst |=> $stable(port_pm_ctrl[15:0]);
  endproperty
  a_stky: assert property (p_stky) else $error("sticky timeout lost");
  property p_global_reset_input;
    s_global_reset_input |=> port_pm_ctrl == 128'h0;
  endproperty
  a_global_reset_input: assert property (p_global_reset_input) else $error("global reset ignored");
  property p_pend;
    intr_event[0] && !host_reset |=> intr_pending[0];
  endproperty
  a_pend: assert property (p_pend) else $error("pending not set");
endmodule
bind port_pm_runtime_registers pm_rt_checker u_chk (.*);

// ---- testbench/port_pm_runtime_registers_test.sv ----
`timescale 1ns/1ps
module port_pm_runtime_registers_test;
  reg clk = 1'b0;
  reg rst_n = 1'b0, global_reset_input = 1'b0, host_reset = 1'b0, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
  reg [31:0] bar0_base = 32'hF000_0000, op_offset = 32'h80, rt_offset = 32'h2000;
  reg [31:0] reg_addr = 32'h0, reg_wdata = 32'h0, d, v;
  reg [11:0] sleep_entry_result = 12'h0;
  reg [63:0] link_error_count = 64'h0;
  reg [7:0] intr_event = 8'h0;
  wire [31:0] reg_rdata;
  wire reg_rd_valid;
  wire [127:0] port_pm_ctrl;
  wire [7:0] intr_enable, intr_pending;
  wire [13:0] periodic_frame_counter;
  integer num_errors = 0, compares = 0, seed = 32'h804C43F3, i, p;
  port_pm_runtime_registers #(.FRAME_TICKS(4)) u_dut (.*);
  always #2.5 clk = ~clk;
  //////////////////////////////////////////////////////////////////////
  function [31:0] pa(input integer n);
    pa = bar0_base + op_offset + 32'h404 + (n << 4);
  endfunction
  function [31:0] ia(input integer n);
    ia = bar0_base + rt_offset + 32'h20 + (n << 5);
  endfunction
  function [31:0] pm_exp(input integer n, input [31:0] w);
    pm_exp = n < 2 ? w & 32'h0001_FFFF : (w & 32'hF000_FFF8) | sleep_entry_result[3*n+:3];
  endfunction
  task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
    compares = compares + 1;
    if (g !== e) begin
      num_errors = num_errors + 1;
      $display("[FAIL] %0s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input [31:0] a, input [31:0] w);
    @(posedge clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= w;
    @(posedge clk);
    reg_wr_en <= 1'b0;
  endtask
  task rd(input [31:0] a);
    @(posedge clk);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    #1;
    chk("valid", 32'h1, reg_rd_valid);
    v = reg_rdata;
  endtask
  task rc(input [31:0] a, input [31:0] e, input [63:0] nm);
    rd(a);
    chk(nm, e, v);
  endtask
  task close_out;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    d = $random(seed);
    sleep_entry_result <= d[11:0];
    link_error_count <= {$random(seed), $random(seed)};
    for (p = 0; p < 4; p = p + 1) begin
      rc(pa(p), pm_exp(p, 32'h0), "pm_rst");
      rc(pa(p) + 32'h4, p < 2 ? link_error_count[16*p+:16] : 32'h0, "link");
    end
    wr(pa(4), 32'hFFFF_FFFF);
    rc(pa(4), 32'h0, "port5");
    $display("test reset done");
    for (i = 0; i < 40; i = i + 1) begin
      p = {$random(seed)} % 4;
      d = (i == 0) ? 32'hFFFF_FFFF : $random(seed);
      wr(pa(p), d);
      rc(pa(p), pm_exp(p, d), "pm_rw");
    end
    $display("test pm done");
    for (p = 0; p < 8; p = p + 1) begin
      rc(ia(p), 32'h0, "im_rst");
      wr(ia(p), 32'hFFFF_FFFE);
      rc(ia(p), 32'h2, "im_en");
      @(posedge clk) intr_event <= 8'h1 << p;
      @(posedge clk) intr_event <= 8'h0;
      rc(ia(p), 32'h3, "im_pend");
      wr(ia(p), 32'h1);
      rc(ia(p), 32'h0, "im_clr");
      rc(ia(p) + 32'h4, 32'h0, "im_gap");
    end
    wr(bar0_base + rt_offset + 32'h4, 32'hFFFF_FFFF);
    rc(bar0_base + rt_offset + 32'h4, 32'h0, "rt_rsvd");
    $display("test intr done");
    for (i = 0; i < 3; i = i + 1) begin
      rd(bar0_base + rt_offset);
      d = {18'h0, v[13:0] + 14'h1};
      repeat (2) @(posedge clk);
      rc(bar0_base + rt_offset, d, "frame");
    end
    $display("test frame done");
    d = $random(seed);
    wr(pa(0), d);
    wr(ia(0), 32'h0000_0002);
    @(posedge clk) intr_event <= 8'h01;
    @(posedge clk) intr_event <= 8'h00;
    @(posedge clk) host_reset <= 1'b1;
    @(posedge clk) host_reset <= 1'b0;
    rc(pa(0), d & 32'h0000_FFFF, "sticky");
    rc(pa(2), pm_exp(2, 32'h0), "hs_clr");
    rc(ia(0), 32'h0, "im_hrst");
    @(posedge clk) global_reset_input <= 1'b1;
    repeat (4) @(posedge clk);
    global_reset_input <= 1'b0;
    rc(pa(0), 32'h0, "global_reset_input");
    $display("test resets done");
    close_out;
  end
  initial begin
    #50000;
    num_errors = num_errors + 1;
    close_out;
  end
endmodule
